//--- core/dsom_rx_overhead_monitor.sv
// dsom_rx_overhead_monitor: receive ds3 overhead monitor. watches the
// x-bits, far-end block error bits, application channel bit and p-bits
// of each received frame, keeps status, sticky events and counters.
// assumes a framer ahead of it marks each bit as overhead or payload,
// gives its f-frame and slot, and pulses rx_frame_end with the last bit.
//
// Behaviour
// [RULE1] both x-bits zero in a received frame declares far-end receive failure
// [RULE2] far-end failure shows as bit 4 of rx_line_status
// [RULE3] that bit follows the condition, it does not latch
// [RULE4] every change of far-end failure sets event bit 3 and interrupts
// [RULE5] both x-bits one clears the far-end failure condition
// [RULE6] remote sends block error bits 111 only when it saw no errors
// [RULE7] a frame with block error bits 111 leaves the counter alone
// [RULE8] a frame with other block error bits bumps the 0x58/0x59 counter
// [RULE9] application bit is third overhead bit of f-frame 1
// [RULE10] latest application bit shows as bit 3 of rx_line_status
// [RULE11] a change of application bit sets event bit 2 and interrupts
// [RULE12] remote puts even payload parity into both p-bits of next frame
// [RULE13] payload parity of each frame is checked against next frame's p-bits
// [RULE14] a parity mismatch sets the p-bit event flag and interrupts
// [RULE15] a parity mismatch makes outgoing block error bits other than 111
// [RULE16] each parity error bumps a 16-bit counter read at 0x54/0x55
// [RULE17] reading the parity counter returns errors since last read, clears it
// [RULE18] latest block error bits show in bits 2..0 of rx_line_status
// [RULE19] event flags below the top bit clear when the register is read
`timescale 1ns/100ps
`include "dsom_cfg.svh"

module dsom_rx_overhead_monitor (
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               resetn,
  // received bit stream from the framer
  input  wire logic               rx_valid,
  input  wire logic               rx_data,
  input  wire logic               rx_ovh,
  input  wire logic [2:0]         rx_sub,
  input  wire logic [2:0]         rx_slot,
  input  wire logic               rx_frame_end,
  // register port
  input  wire dsom_pkg::dsom_addr_t reg_addr,
  input  wire dsom_pkg::dsom_byte_t reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output dsom_pkg::dsom_byte_t    reg_rdata,
  // status toward the system
  output logic                    far_failure_flag,
  output logic                    app_channel_bit,
  output logic [2:0]              far_block_error_bits,
  output logic                    irq,
  // block error code for the local transmitter
  output logic [2:0]              tx_far_block_error_bits
);

  import dsom_pkg::*;

  dsom_state_t state;
  dsom_state_t next_state;

  dsom_cnt_t   par_count;
  dsom_cnt_t   far_end_block_error_count;

  logic        par_inc;
  logic        par_clr;
  logic        far_end_block_error_inc;
  logic        far_end_block_error_clr;

  logic        payload_bit;
  logic        frame_parity;
  logic        frame_done;
  logic        x_alarm;
  logic        x_clear;
  logic        far_end_receive_failure_now;
  logic        far_end_receive_failure_change;
  logic        aic_change;
  logic        par_err;
  logic        far_end_block_error_err;
  dsom_byte_t  line_status;
  dsom_byte_t  evt_set;

  // parity error counter, high byte read clears it
  dsom_evcount #(
    .W      (`DSOM_CNT_W)
  ) u_par_count (
    .mclk   (mclk),
    .resetn (resetn),
    .inc    (par_inc),
    .clr    (par_clr),
    .count  (par_count)
  );

  // far-end block error counter, same read discipline
  dsom_evcount #(
    .W      (`DSOM_CNT_W)
  ) u_far_end_block_error_count (
    .mclk   (mclk),
    .resetn (resetn),
    .inc    (far_end_block_error_inc),
    .clr    (far_end_block_error_clr),
    .count  (far_end_block_error_count)
  );

  always_comb begin
    next_state   = state;
    payload_bit  = 1'b0;
    frame_parity = 1'b0;
    frame_done   = 1'b0;
    x_alarm      = 1'b0;
    x_clear      = 1'b0;
    far_end_receive_failure_now     = state.far_end_receive_failure;
    far_end_receive_failure_change  = 1'b0;
    aic_change   = 1'b0;
    par_err      = 1'b0;
    far_end_block_error_err     = 1'b0;
    par_inc      = 1'b0;
    far_end_block_error_inc     = 1'b0;
    par_clr      = 1'b0;
    far_end_block_error_clr     = 1'b0;
    evt_set      = `DSOM_RST_BYTE;
    line_status  = `DSOM_RST_BYTE;

    // overhead capture; the last bit of a frame is seen before evaluation
    if (rx_valid && rx_ovh) begin
      unique case (rx_sub)
        `DSOM_SUB_1: begin
          if (rx_slot == `DSOM_SLOT_LEAD) begin
            next_state.x_cap[0] = rx_data;
          end
          if (rx_slot == `DSOM_SLOT_C1) begin
            next_state.aic_cap = rx_data; // [RULE9]
          end
        end
        `DSOM_SUB_2: begin
          if (rx_slot == `DSOM_SLOT_LEAD) begin
            next_state.x_cap[1] = rx_data;
          end
        end
        `DSOM_SUB_3: begin
          if (rx_slot == `DSOM_SLOT_LEAD) begin
            next_state.p_cap[0] = rx_data;
          end
        end
        `DSOM_SUB_4: begin
          if (rx_slot == `DSOM_SLOT_LEAD) begin
            next_state.p_cap[1] = rx_data;
          end
          if (rx_slot == `DSOM_SLOT_C1) begin
            next_state.far_end_block_error_cap[2] = rx_data;
          end
          if (rx_slot == `DSOM_SLOT_C2) begin
            next_state.far_end_block_error_cap[1] = rx_data;
          end
          if (rx_slot == `DSOM_SLOT_C3) begin
            next_state.far_end_block_error_cap[0] = rx_data;
          end
        end
        default: begin
        end
      endcase
    end

    // even parity of the payload bits only
    payload_bit  = rx_valid && !rx_ovh && rx_data;
    frame_parity = state.par_acc ^ payload_bit; // [RULE13]
    next_state.par_acc = frame_parity;
    frame_done   = rx_valid && rx_frame_end;

    if (frame_done) begin
      next_state.par_acc   = 1'b0;
      next_state.par_prev  = frame_parity;
      next_state.have_prev = 1'b1;

      // x-bits in between the two patterns leave the condition as it was
      x_alarm = (next_state.x_cap == `DSOM_X_ALARM);
      x_clear = (next_state.x_cap == `DSOM_X_CLEAR);
      if (x_alarm) begin
        far_end_receive_failure_now = 1'b1; // [RULE1]
      end else if (x_clear) begin
        far_end_receive_failure_now = 1'b0; // [RULE5]
      end
      far_end_receive_failure_change     = (far_end_receive_failure_now != state.far_end_receive_failure); // [RULE4]
      next_state.far_end_receive_failure = far_end_receive_failure_now; // [RULE3]

      // the first frame after reset has nothing to compare against
      aic_change     = state.have_prev && (next_state.aic_cap != state.app_identification_channel); // [RULE11]
      next_state.app_identification_channel = next_state.aic_cap; // [RULE10]

      // both p-bits must carry the parity of the previous payload
      par_err = state.have_prev &&
                ((next_state.p_cap[0] != state.par_prev) ||
                 (next_state.p_cap[1] != state.par_prev)); // [RULE13]
      par_inc = par_err; // [RULE16]
      next_state.tx_far_end_block_error = par_err ? `DSOM_FAR_END_BLOCK_ERROR_ERR : `DSOM_FAR_END_BLOCK_ERROR_OK; // [RULE15]

      // 111 is an error-free report and is not counted
      far_end_block_error_err             = (next_state.far_end_block_error_cap != `DSOM_FAR_END_BLOCK_ERROR_OK); // [RULE7]
      far_end_block_error_inc             = far_end_block_error_err; // [RULE8]
      next_state.far_end_block_error_last = next_state.far_end_block_error_cap; // [RULE18]
    end

    evt_set[`DSOM_EV_FAR_END_RECEIVE_FAILURE] = far_end_receive_failure_change; // [RULE4]
    evt_set[`DSOM_EV_AIC]  = aic_change; // [RULE11]
    evt_set[`DSOM_EV_PBIT] = par_err; // [RULE14]

    line_status[`DSOM_LS_FAR_END_RECEIVE_FAILURE] = state.far_end_receive_failure; // [RULE2]
    line_status[`DSOM_LS_AIC]  = state.app_identification_channel; // [RULE10]
    line_status[`DSOM_LS_FAR_END_BLOCK_ERROR_HI:`DSOM_LS_FAR_END_BLOCK_ERROR_LO] = state.far_end_block_error_last; // [RULE18]

    // read data stands in the cycle after the strobe only
    next_state.rdata = `DSOM_RST_BYTE;
    if (reg_rd) begin
      unique case (reg_addr)
        `DSOM_ADDR_LINE_STAT: begin
          next_state.rdata = line_status;
        end
        `DSOM_ADDR_EVT_STAT: begin
          next_state.rdata = state.evt;
          next_state.evt   = state.evt & ~`DSOM_EV_RUR_MASK; // [RULE19]
        end
        `DSOM_ADDR_EVT_MASK: begin
          next_state.rdata = state.mask;
        end
        `DSOM_ADDR_PAR_HI: begin
          // high byte first: low byte is frozen so the pair is coherent
          next_state.rdata       = par_count[`DSOM_CNT_W-1:`DSOM_DW];
          next_state.par_lo_hold = par_count[`DSOM_DW-1:0];
          par_clr                = 1'b1; // [RULE17]
        end
        `DSOM_ADDR_PAR_LO: begin
          next_state.rdata = state.par_lo_hold; // [RULE17]
        end
        `DSOM_ADDR_FAR_END_BLOCK_ERROR_HI: begin
          next_state.rdata        = far_end_block_error_count[`DSOM_CNT_W-1:`DSOM_DW];
          next_state.far_end_block_error_lo_hold = far_end_block_error_count[`DSOM_DW-1:0];
          far_end_block_error_clr                = 1'b1;
        end
        `DSOM_ADDR_FAR_END_BLOCK_ERROR_LO: begin
          next_state.rdata = state.far_end_block_error_lo_hold;
        end
        default: begin
          next_state.rdata = `DSOM_RST_BYTE;
        end
      endcase
    end

    // writes: one-to-clear events, plain mask
    if (reg_wr) begin
      if (reg_addr == `DSOM_ADDR_EVT_STAT) begin
        next_state.evt = state.evt & ~(reg_wdata & `DSOM_EV_RUR_MASK);
      end
      if (reg_addr == `DSOM_ADDR_EVT_MASK) begin
        next_state.mask = reg_wdata & `DSOM_EV_RUR_MASK;
      end
    end

    // a new event beats a clear in the same cycle
    next_state.evt = next_state.evt | evt_set; // [RULE4] [RULE14]
    next_state.evt[`DSOM_EV_CP] = 1'b0;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state              <= '0;
      state.far_end_block_error_last    <= `DSOM_RST_FAR_END_BLOCK_ERROR;
      state.far_end_block_error_cap     <= `DSOM_RST_FAR_END_BLOCK_ERROR;
      state.tx_far_end_block_error      <= `DSOM_RST_FAR_END_BLOCK_ERROR;
      state.mask         <= `DSOM_RST_MASK;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata               = state.rdata;
  assign far_failure_flag        = state.far_end_receive_failure; // [RULE3]
  assign app_channel_bit         = state.app_identification_channel;
  assign far_block_error_bits    = state.far_end_block_error_last;
  assign tx_far_block_error_bits = state.tx_far_end_block_error; // [RULE15]
  // level interrupt while any unmasked sticky event stands
  assign irq                     = |(state.evt & state.mask); // [RULE4] [RULE11] [RULE14]

endmodule // dsom_rx_overhead_monitor

//--- core/dsom_cfg.svh
// dsom_cfg.svh: offsets, field positions, reset values and codes of the
// ds3 receive overhead monitor. definitions only, included by bare name.
`ifndef DSOM_CFG_SVH
`define DSOM_CFG_SVH

`define DSOM_AW             8
`define DSOM_DW             8
`define DSOM_CNT_W          16

// register byte addresses
`define DSOM_ADDR_LINE_STAT 8'h11
`define DSOM_ADDR_EVT_STAT  8'h13
`define DSOM_ADDR_EVT_MASK  8'h14
`define DSOM_ADDR_PAR_HI    8'h54
`define DSOM_ADDR_PAR_LO    8'h55
`define DSOM_ADDR_FAR_END_BLOCK_ERROR_HI   8'h58
`define DSOM_ADDR_FAR_END_BLOCK_ERROR_LO   8'h59

// rx_line_status fields
`define DSOM_LS_FAR_END_RECEIVE_FAILURE        4
`define DSOM_LS_AIC         3
`define DSOM_LS_FAR_END_BLOCK_ERROR_HI     2
`define DSOM_LS_FAR_END_BLOCK_ERROR_LO     0

// rx_event_status fields
`define DSOM_EV_CP          7
`define DSOM_EV_FAR_END_RECEIVE_FAILURE        3
`define DSOM_EV_AIC         2
`define DSOM_EV_PBIT        0
`define DSOM_EV_RUR_MASK    8'h7F

// reset values
`define DSOM_RST_BYTE       8'h00
`define DSOM_RST_MASK       8'h00
`define DSOM_RST_FAR_END_BLOCK_ERROR       3'h7

// far-end block error codes
`define DSOM_FAR_END_BLOCK_ERROR_OK        3'h7
`define DSOM_FAR_END_BLOCK_ERROR_ERR       3'h0

// x-bit patterns
`define DSOM_X_ALARM        2'h0
`define DSOM_X_CLEAR        2'h3

// overhead positions: f-frame number and overhead slot within it
`define DSOM_SUB_1          3'h1
`define DSOM_SUB_2          3'h2
`define DSOM_SUB_3          3'h3
`define DSOM_SUB_4          3'h4
`define DSOM_SLOT_LEAD      3'h0
`define DSOM_SLOT_C1        3'h2
`define DSOM_SLOT_C2        3'h4
`define DSOM_SLOT_C3        3'h6

`endif

//--- core/dsom_pkg.sv
// dsom_pkg: state types of the ds3 receive overhead monitor.
// assumes dsom_cfg.svh is on the include path.
`include "dsom_cfg.svh"

package dsom_pkg;

  typedef logic [`DSOM_AW-1:0]    dsom_addr_t;
  typedef logic [`DSOM_DW-1:0]    dsom_byte_t;
  typedef logic [`DSOM_CNT_W-1:0] dsom_cnt_t;

  // state of the monitor apart from its two event counters, registered as one word
  typedef struct packed {
    logic       par_acc;
    logic       par_prev;
    logic       have_prev;
    logic [1:0] x_cap;
    logic [2:0] far_end_block_error_cap;
    logic       aic_cap;
    logic [1:0] p_cap;
    logic       far_end_receive_failure;
    logic       app_identification_channel;
    logic [2:0] far_end_block_error_last;
    logic [2:0] tx_far_end_block_error;
    dsom_byte_t evt;
    dsom_byte_t mask;
    dsom_byte_t rdata;
    dsom_byte_t par_lo_hold;
    dsom_byte_t far_end_block_error_lo_hold;
  } dsom_state_t;

endpackage

//--- core/dsom_evcount.sv
// dsom_evcount: saturating event counter, cleared by a read.
// assumes inc and clr are one-cycle pulses on mclk.
`timescale 1ns/100ps
`include "dsom_cfg.svh"

module dsom_evcount #(
  parameter int W = `DSOM_CNT_W
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         resetn,
  // events
  input  wire logic         inc,
  input  wire logic         clr,
  // count
  output logic [W-1:0]      count
);

  typedef struct packed {
    logic [W-1:0] count;
  } dsom_cnt_state_t;

  dsom_cnt_state_t state;
  dsom_cnt_state_t next_state;

  // an event in the clearing cycle counts as the first of the new period
  always_comb begin
    next_state = state;
    if (clr) begin
      next_state.count = {{(W-1){1'b0}}, inc};
    end else if (inc && (state.count != {W{1'b1}})) begin
      next_state.count = state.count + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign count = state.count;

endmodule // dsom_evcount

//--- verification/dsom_remote_term.sv
// dsom_remote_term: remote ds3 terminal seen through the framer, one frame a call.
// assumes a single caller; the stream idles between frames.
`timescale 1ns/100ps
module dsom_remote_term (
  // clock
  input  wire logic  mclk,
  // framed bit stream toward the monitor
  output logic       rx_valid,
  output logic       rx_data,
  output logic       rx_ovh,
  output logic [2:0] rx_sub,
  output logic [2:0] rx_slot,
  output logic       rx_frame_end
);
  logic par = 1'b0;
  int   seed = 32'hbdd41cd4;
  initial {rx_valid, rx_data, rx_ovh, rx_sub, rx_slot, rx_frame_end} = '0;
  task automatic put(input logic d, input logic o, input logic [5:0] pos, input logic e);
    @(posedge mclk);
    {rx_valid, rx_data, rx_ovh, rx_sub, rx_slot, rx_frame_end} <= {1'b1, d, o, pos, e};
  endtask
  // perr spoils only the first p-bit, so one bad copy alone must be caught
  task automatic send_frame(input logic [1:0] x, input logic a, input logic [2:0] f,
                            input logic perr);
    logic np;
    logic d;
    put(x[1], 1'b1, 6'h08, 1'b0);
    put(x[0], 1'b1, 6'h10, 1'b0);
    put(par ^ perr, 1'b1, 6'h18, 1'b0);
    put(par, 1'b1, 6'h20, 1'b0);
    put(a, 1'b1, 6'h0A, 1'b0);
    put(f[2], 1'b1, 6'h22, 1'b0);
    put(f[1], 1'b1, 6'h24, 1'b0);
    put(f[0], 1'b1, 6'h26, 1'b0);
    np = 1'b0;
    for (int i = 0; i < 8; i++) begin
      d = 1'($random(seed));
      np = np ^ d;
      put(d, 1'b0, 6'h00, i == 7);
    end
    par = np;
    @(posedge mclk);
    {rx_valid, rx_data, rx_frame_end} <= {1'b0, ~rx_data, 1'b0};
  endtask
endmodule // dsom_remote_term

//--- verification/dsom_monitor_props.sv
// dsom_monitor_props: port-level assertions on the overhead monitor.
// assumes frames never end on an overhead bit; bound in by the bench.
`timescale 1ns/100ps
module dsom_monitor_props (
  // clock and reset
  input wire logic                 mclk,
  input wire logic                 resetn,
  // stream
  input wire logic                 rx_valid,
  input wire logic                 rx_data,
  input wire logic                 rx_ovh,
  input wire logic [2:0]           rx_sub,
  input wire logic [2:0]           rx_slot,
  input wire logic                 rx_frame_end,
  // registers and status
  input wire dsom_pkg::dsom_addr_t reg_addr,
  input wire logic                 reg_rd,
  input wire dsom_pkg::dsom_byte_t reg_rdata,
  input wire logic                 far_failure_flag,
  input wire logic                 app_channel_bit,
  input wire logic [2:0]           far_block_error_bits,
  input wire logic [2:0]           tx_far_block_error_bits
);
  import dsom_pkg::*;
  logic [1:0] xc;
  logic [1:0] pc;
  logic [2:0] fc;
  logic       ac, pa, pv, hv, fe, pn, mis;
  assign fe = rx_valid && rx_frame_end;
  assign pn = pa ^ (rx_valid && !rx_ovh && rx_data);
  // the first frame has no earlier payload to judge against
  assign mis = hv && (pc != {2{pv}});
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      {xc, pc, fc, ac, pa, pv, hv} <= '0;
    end else begin
      if (rx_valid && rx_ovh) begin
        case ({rx_sub, rx_slot})
          6'h08: xc[1] <= rx_data;
          6'h10: xc[0] <= rx_data;
          6'h18: pc[1] <= rx_data;
          6'h20: pc[0] <= rx_data;
          6'h0A: ac <= rx_data;
          6'h22: fc[2] <= rx_data;
          6'h24: fc[1] <= rx_data;
          6'h26: fc[0] <= rx_data;
          default: ;
        endcase
      end
      pa <= fe ? 1'b0 : pn;
      if (fe) {pv, hv} <= {pn, 1'b1};
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_far_end_receive_failure_set: assert property (fe && xc == 2'h0 |=> far_failure_flag)
    else $error("far-end failure not raised");
  a_far_end_receive_failure_clear: assert property (fe && xc == 2'h3 |=> !far_failure_flag)
    else $error("far-end failure not cleared");
  a_far_end_receive_failure_hold: assert property ((!fe || xc[1] != xc[0]) |=> $stable(far_failure_flag))
    else $error("far-end failure moved without cause");
  a_aic_copy: assert property (fe |=> app_channel_bit == $past(ac))
    else $error("application bit not copied");
  a_far_end_block_error_copy: assert property (fe |=> far_block_error_bits == $past(fc))
    else $error("block error bits not copied");
  a_tx_err: assert property (fe && mis |=> tx_far_block_error_bits == 3'h0)
    else $error("parity error not sent back");
  a_tx_ok: assert property (fe && !mis |=> tx_far_block_error_bits == 3'h7)
    else $error("clean frame sent back as error");
  a_line_read: assert property (reg_rd && reg_addr == 8'h11 |=>
    reg_rdata == {3'h0, $past(far_failure_flag), $past(app_channel_bit),
                  $past(far_block_error_bits)})
    else $error("line status read wrong");
  a_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  c_alarm: cover property (fe && xc == 2'h0);
  c_perr: cover property (fe && mis);
  c_evt_read: cover property (reg_rd && reg_addr == 8'h13);
endmodule // dsom_monitor_props

//--- verification/tb_dsom_rx_overhead_monitor.sv
// tb_dsom_rx_overhead_monitor: self-checking bench for the overhead monitor.
// assumes the remote terminal model and the checker are compiled first.
`timescale 1ns/100ps
module tb_dsom_rx_overhead_monitor;
  import dsom_pkg::*;
  logic        mclk, resetn, rx_valid, rx_data, rx_ovh, rx_frame_end;
  logic        reg_wr, reg_rd, irq, ffl, aicb, ef, ea, first;
  logic [2:0]  rx_sub, rx_slot, far_end_block_error, txfe, lf;
  dsom_addr_t  reg_addr;
  dsom_byte_t  reg_wdata, reg_rdata, ev, msk;
  logic [15:0] npe, nfe;
  logic [31:0] r;
  int          seed = 32'hbdd41cd4;
  int          error_cnt = 0;
  int          compares = 0;
  dsom_rx_overhead_monitor dut (
    .mclk(mclk), .resetn(resetn), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ovh(rx_ovh),
    .rx_sub(rx_sub), .rx_slot(rx_slot), .rx_frame_end(rx_frame_end), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .far_failure_flag(ffl), .app_channel_bit(aicb), .far_block_error_bits(far_end_block_error),
    .irq(irq), .tx_far_block_error_bits(txfe));
  dsom_remote_term rmt (
    .mclk(mclk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ovh(rx_ovh),
    .rx_sub(rx_sub), .rx_slot(rx_slot), .rx_frame_end(rx_frame_end));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic conclude();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task automatic fr(input logic [1:0] x, input logic a, input logic [2:0] f, input logic pe);
    logic p;
    rmt.send_frame(x, a, f, pe);
    #1;
    p = pe && !first;
    if ((x == 2'h0 || x == 2'h3) && ef != ~x[0]) ev[3] = 1'b1;
    if (x == 2'h0 || x == 2'h3) ef = ~x[0];
    if (!first && a != ea) ev[2] = 1'b1;
    if (p) ev[0] = 1'b1;
    if (p) npe++;
    if (f != 3'h7) nfe++;
    {ea, lf, first} = {a, f, 1'b0};
    chk(8'(ffl), 8'(ef));
    chk(8'(aicb), 8'(a));
    chk(8'(far_end_block_error), 8'(f));
    chk(8'(txfe), p ? 8'h00 : 8'h07);
    chk(8'(irq), 8'(|(ev & msk)));
  endtask
  task automatic drain();
    rd(8'h11, {3'h0, ef, ea, lf});
    rd(8'h13, ev);
    ev = 8'h00;
    rd(8'h13, 8'h00);
    rd(8'h54, npe[15:8]);
    rd(8'h55, npe[7:0]);
    rd(8'h58, nfe[15:8]);
    rd(8'h59, nfe[7:0]);
    rd(8'h54, 8'h00);
    {npe, nfe} = '0;
  endtask
  initial begin
    {resetn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {ev, msk, npe, nfe, ef, ea, lf, first} = {50'h0, 3'h7, 1'b1};
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    rd(8'h14, 8'h00);
    wr(8'h11, 8'hFF);
    rd(8'h20, 8'h00);
    drain();
    // first frame after reset: parity and application change are not judged
    fr(2'h0, 1'b1, 3'h7, 1'b1);
    fr(2'h1, 1'b0, 3'h2, 1'b1);
    fr(2'h3, 1'b0, 3'h7, 1'b1);
    drain();
    wr(8'h14, 8'hFF);
    rd(8'h14, 8'h7F);
    wr(8'h14, 8'h0D);
    msk = 8'h0D;
    fr(2'h0, 1'b1, 3'h0, 1'b1);
    wr(8'h13, 8'h01);
    ev[0] = 1'b0;
    chk(8'(irq), 8'(|(ev & msk)));
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      fr(r[1:0], r[2], r[3] ? 3'h7 : r[6:4], r[9:7] == 3'h0);
      if (i % 8 == 7) drain();
    end
    conclude();
  end
  initial begin
    #200000;
    error_cnt++;
    conclude();
  end
endmodule // tb_dsom_rx_overhead_monitor

bind dsom_rx_overhead_monitor dsom_monitor_props u_props (
  .mclk(mclk), .resetn(resetn), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ovh(rx_ovh),
  .rx_sub(rx_sub), .rx_slot(rx_slot), .rx_frame_end(rx_frame_end), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .far_failure_flag(far_failure_flag),
  .app_channel_bit(app_channel_bit), .far_block_error_bits(far_block_error_bits),
  .tx_far_block_error_bits(tx_far_block_error_bits));
